// >>> include/ofsw_pkg.sv
// ofsw_pkg: shared constants for the output fault and status word block
package ofsw_pkg;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int OFSW_NUM_CH = 6;
	localparam int OFSW_WORD_W = 16;
	// ------------------------------------------------------------
	// module fault summary word field positions
	// ------------------------------------------------------------
	localparam int OFSW_MF_ANALOG_GRP_BIT = 15;
	localparam int OFSW_MF_OUTPUT_GRP_BIT = 14;
	localparam int OFSW_MF_CALIBRATING_BIT = 12;
	localparam int OFSW_MF_CAL_ERROR_BIT = 11;
	// ------------------------------------------------------------
	// forced channel fault patterns and status layout
	// ------------------------------------------------------------
	localparam logic [15:0] OFSW_CF_CAL_PATTERN = 16'h003F;
	localparam logic [15:0] OFSW_CF_COMM_LOSS_PATTERN = 16'hFFFF;
	localparam int OFSW_HOLD_TOP_BIT = 14;
	// hold release window: 0.1 percent of full scale, in thousandths
	localparam int OFSW_HOLD_WINDOW_PERMILLE = 1;
	localparam logic [15:0] OFSW_FULL_SCALE = 16'hFFFF;
	// ------------------------------------------------------------
	// apb register map (byte addresses) and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] OFSW_ADDR_MODULE_FAULT = 8'h00;
	localparam logic [7:0] OFSW_ADDR_CHANNEL_FAULT = 8'h04;
	localparam logic [7:0] OFSW_ADDR_CHANNEL_STATUS = 8'h08;
	localparam logic [7:0] OFSW_ADDR_CONTROL = 8'h0C;
	localparam logic [7:0] OFSW_ADDR_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFSW_ADDR_IRQ_MASK = 8'h14;
	localparam logic [15:0] OFSW_WORD_RESET = 16'h0000;
	localparam logic [2:0] OFSW_IRQ_RESET = 3'h0;
	localparam logic [31:0] OFSW_UNMAPPED_READ = 32'h00000000;
	// interrupt status bit positions
	localparam int OFSW_IRQ_FAULT_BIT = 0;
	localparam int OFSW_IRQ_CAL_BIT = 1;
	localparam int OFSW_IRQ_HOLD_BIT = 2;
	localparam int OFSW_IRQ_W = 3;
endpackage

// >>> include/ofsw_ch_if.sv
// ofsw_ch_if: per-channel conditions carried between the block's modules
`timescale 1ns/10ps
`default_nettype none
interface ofsw_ch_if #(parameter int NUM_CH = 6, parameter int VAL_W = 16);
	logic [NUM_CH-1:0] hold_active;
	logic [NUM_CH*VAL_W-1:0] request_value;
	logic [NUM_CH*VAL_W-1:0] echo_value;
	logic [NUM_CH-1:0] hold_flag;
	modport tracker (input hold_active, input request_value, input echo_value, output hold_flag);
	modport top (output hold_active, output request_value, output echo_value, input hold_flag);
endinterface
`default_nettype wire

// >>> hdl/ofsw_hold_tracker.sv
// ofsw_hold_tracker: per-channel output-in-hold flag tracking
`timescale 1ns/10ps
`default_nettype none
module ofsw_hold_tracker
	import ofsw_pkg::*;
#(
	parameter int NUM_CH = 6,
	parameter int VAL_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	ofsw_ch_if.tracker ch
);
	// ------------------------------------------------------------
	// release window
	// ------------------------------------------------------------
	// window rounded down so release never happens outside 0.1 percent
	localparam logic [VAL_W-1:0] WINDOW = VAL_W'((32'(OFSW_FULL_SCALE) * OFSW_HOLD_WINDOW_PERMILLE) / 1000);

	function automatic logic within_window(input logic [VAL_W-1:0] a, input logic [VAL_W-1:0] b);
		logic [VAL_W-1:0] diff;
		diff = (a > b) ? VAL_W'(a - b) : VAL_W'(b - a);
		return diff <= WINDOW;
	endfunction

	// ------------------------------------------------------------
	// hold flags
	// ------------------------------------------------------------
	// set while holding wins over release in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ch.hold_flag <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (ch.hold_active[i]) begin
					ch.hold_flag[i] <= 1'b1;
				end else if (within_window(ch.request_value[i*VAL_W +: VAL_W], ch.echo_value[i*VAL_W +: VAL_W])) begin
					ch.hold_flag[i] <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> hdl/ofsw_word_pack.sv
// ofsw_word_pack: combinational packing of the three reported words
`timescale 1ns/10ps
`default_nettype none
module ofsw_word_pack
	import ofsw_pkg::*;
#(
	parameter int NUM_CH = 6
) (
	input wire logic [NUM_CH-1:0] limit_alarm,
	input wire logic [NUM_CH-1:0] calibrating,
	input wire logic [NUM_CH-1:0] cal_error,
	input wire logic comm_lost,
	input wire logic [NUM_CH-1:0] hold_flag,
	output logic [15:0] module_word,
	output logic [15:0] channel_word,
	output logic [15:0] status_word
);
	// ------------------------------------------------------------
	// channel fault word
	// ------------------------------------------------------------
	always_comb begin
		channel_word = 16'(limit_alarm);
		if (|calibrating) begin
			channel_word = OFSW_CF_CAL_PATTERN;
		end
		// comm loss wins: the controller sees all ones
		if (comm_lost) begin
			channel_word = OFSW_CF_COMM_LOSS_PATTERN;
		end
	end

	// ------------------------------------------------------------
	// module fault summary word, bits 15..11 only
	// ------------------------------------------------------------
	always_comb begin
		module_word = OFSW_WORD_RESET;
		module_word[OFSW_MF_ANALOG_GRP_BIT] = |channel_word;
		module_word[OFSW_MF_OUTPUT_GRP_BIT] = |channel_word;
		module_word[OFSW_MF_CALIBRATING_BIT] = |calibrating;
		module_word[OFSW_MF_CAL_ERROR_BIT] = |cal_error;
	end

	// ------------------------------------------------------------
	// shared status word: hold flags on even bits, odd bits zero
	// ------------------------------------------------------------
	always_comb begin
		status_word = OFSW_WORD_RESET;
		for (int i = 0; i < NUM_CH; i++) begin
			status_word[OFSW_HOLD_TOP_BIT - 2*i] = hold_flag[i];
		end
	end
endmodule
`default_nettype wire

// >>> hdl/ofsw_top.sv
// ofsw_top: integer-mode fault and status words with apb access
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - summary fault flags occupy bits 15 to 11 of module fault word
// - analog group flag set when any channel fault bit is set
// - output group flag set when any channel fault bit is set
// - during calibration set calibrating flag and force all channel fault bits
// - calibration error flag set when any channel has a calibration error
// - channel faults use bits 5..0; calibration shows 003F
// - lost controller communication makes channel fault word read FFFF
// - one status word for all six channels, carrying only hold
// - hold flag set while holding, cleared when request within 0.1% of echo
// - odd status bits 15 to 5 carry nothing and read zero
// - calibration error flag sits at module fault bit 11
module ofsw_top
	import ofsw_pkg::*;
#(
	parameter int NUM_CH = OFSW_NUM_CH,
	parameter int VAL_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// channel conditions from the output engine, same clock
	input wire logic [NUM_CH-1:0] limit_alarm,
	input wire logic [NUM_CH-1:0] calibrating,
	input wire logic [NUM_CH-1:0] cal_error,
	input wire logic [NUM_CH-1:0] hold_active,
	input wire logic [NUM_CH*VAL_W-1:0] request_value,
	input wire logic [NUM_CH*VAL_W-1:0] echo_value,
	input wire logic data_update,
	// communication watchdog from the backplane, asynchronous
	input wire logic comm_lost_pin,
	// reported words
	output logic [15:0] module_fault_summary_word,
	output logic [15:0] channel_fault_word,
	output logic [15:0] shared_channel_status_word,
	output logic irq
);
	// ------------------------------------------------------------
	// comm loss synchroniser
	// ------------------------------------------------------------
	logic comm_meta;
	logic comm_lost;

	// first stage read only by the second
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			comm_meta <= 1'b0;
			comm_lost <= 1'b0;
		end else if (clk_en) begin
			comm_meta <= comm_lost_pin;
			comm_lost <= comm_meta;
		end
	end

	// ------------------------------------------------------------
	// hold tracking and word packing
	// ------------------------------------------------------------
	ofsw_ch_if #(.NUM_CH(NUM_CH), .VAL_W(VAL_W)) ch_bus ();

	assign ch_bus.hold_active = hold_active;
	assign ch_bus.request_value = request_value;
	assign ch_bus.echo_value = echo_value;

	ofsw_hold_tracker #(.NUM_CH(NUM_CH), .VAL_W(VAL_W)) u_hold (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.ch(ch_bus.tracker)
	);

	logic [15:0] next_module_word;
	logic [15:0] next_channel_word;
	logic [15:0] next_status_word;

	ofsw_word_pack #(.NUM_CH(NUM_CH)) u_pack (
		.limit_alarm(limit_alarm),
		.calibrating(calibrating),
		.cal_error(cal_error),
		.comm_lost(comm_lost),
		.hold_flag(ch_bus.hold_flag),
		.module_word(next_module_word),
		.channel_word(next_channel_word),
		.status_word(next_status_word)
	);

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	// bit 0: refresh every cycle instead of only on data_update
	logic free_run;
	logic wr_en;
	logic rd_en;
	logic ctrl_wr;
	logic mask_wr;
	logic status_rd;

	// a transfer takes effect only at the edge where pready is seen
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && penable && !pwrite && pready;
	assign ctrl_wr = wr_en && paddr == OFSW_ADDR_CONTROL;
	assign mask_wr = wr_en && paddr == OFSW_ADDR_IRQ_MASK;
	assign status_rd = rd_en && paddr == OFSW_ADDR_IRQ_STATUS;

	// free-run bit, the only writable bit of the control register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			free_run <= 1'b0;
		end else if (clk_en && ctrl_wr) begin
			free_run <= pwdata[0];
		end
	end

	// ------------------------------------------------------------
	// reported words, snapshot on each data update
	// ------------------------------------------------------------
	// snapshot keeps the three words mutually consistent per update
	logic refresh;

	assign refresh = data_update || free_run;

	// module fault summary word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			module_fault_summary_word <= OFSW_WORD_RESET;
		end else if (clk_en && refresh) begin
			module_fault_summary_word <= next_module_word;
		end
	end

	// channel fault word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			channel_fault_word <= OFSW_WORD_RESET;
		end else if (clk_en && refresh) begin
			channel_fault_word <= next_channel_word;
		end
	end

	// shared channel status word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shared_channel_status_word <= OFSW_WORD_RESET;
		end else if (clk_en && refresh) begin
			shared_channel_status_word <= next_status_word;
		end
	end

	// ------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------
	logic [OFSW_IRQ_W-1:0] irq_status;
	logic [OFSW_IRQ_W-1:0] irq_mask;
	logic [OFSW_IRQ_W-1:0] irq_event;
	logic [15:0] prev_status_word;
	logic prev_fault;
	logic prev_cal;

	// rising edges of fault, calibration error and any hold flag
	always_comb begin
		irq_event = '0;
		irq_event[OFSW_IRQ_FAULT_BIT] = (|channel_fault_word) && !prev_fault;
		irq_event[OFSW_IRQ_CAL_BIT] = module_fault_summary_word[OFSW_MF_CAL_ERROR_BIT] && !prev_cal;
		irq_event[OFSW_IRQ_HOLD_BIT] = |(shared_channel_status_word & ~prev_status_word);
	end

	// last fault level, for the channel fault edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_fault <= 1'b0;
		end else if (clk_en) begin
			prev_fault <= |channel_fault_word;
		end
	end

	// last calibration error level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_cal <= 1'b0;
		end else if (clk_en) begin
			prev_cal <= module_fault_summary_word[OFSW_MF_CAL_ERROR_BIT];
		end
	end

	// last status word, so each hold bit edge counts once
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_status_word <= OFSW_WORD_RESET;
		end else if (clk_en) begin
			prev_status_word <= shared_channel_status_word;
		end
	end

	// read clears, but a same-cycle event still sets
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= OFSW_IRQ_RESET;
		end else if (clk_en) begin
			if (status_rd) begin
				irq_status <= irq_event;
			end else begin
				irq_status <= irq_status | irq_event;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= OFSW_IRQ_RESET;
		end else if (clk_en && mask_wr) begin
			irq_mask <= pwdata[OFSW_IRQ_W-1:0];
		end
	end

	// registered so the pin comes straight from a flip-flop
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// ------------------------------------------------------------
	// apb slave: one wait state, read data registered
	// ------------------------------------------------------------
	function automatic logic addr_mapped(input logic [7:0] a);
		return a == OFSW_ADDR_MODULE_FAULT || a == OFSW_ADDR_CHANNEL_FAULT ||
			a == OFSW_ADDR_CHANNEL_STATUS || a == OFSW_ADDR_CONTROL ||
			a == OFSW_ADDR_IRQ_STATUS || a == OFSW_ADDR_IRQ_MASK;
	endfunction

	// only the two control registers take writes
	function automatic logic addr_writable(input logic [7:0] a);
		return a == OFSW_ADDR_CONTROL || a == OFSW_ADDR_IRQ_MASK;
	endfunction

	// decode in the first access cycle; the answer follows one edge later
	logic access_first;
	logic [31:0] next_prdata;
	logic next_pslverr;

	assign access_first = psel && penable && !pready;

	// read mux: words in the low half, upper bits read zero
	always_comb begin
		next_prdata = OFSW_UNMAPPED_READ;
		if (access_first && !pwrite) begin
			unique case (paddr)
				OFSW_ADDR_MODULE_FAULT: next_prdata = {16'h0000, module_fault_summary_word};
				OFSW_ADDR_CHANNEL_FAULT: next_prdata = {16'h0000, channel_fault_word};
				OFSW_ADDR_CHANNEL_STATUS: next_prdata = {16'h0000, shared_channel_status_word};
				OFSW_ADDR_CONTROL: next_prdata = {31'h00000000, free_run};
				OFSW_ADDR_IRQ_STATUS: next_prdata = {29'h00000000, irq_status};
				OFSW_ADDR_IRQ_MASK: next_prdata = {29'h00000000, irq_mask};
				default: next_prdata = OFSW_UNMAPPED_READ;
			endcase
		end
	end

	// writes to the status words are refused: they are read-only
	always_comb begin
		next_pslverr = 1'b0;
		if (access_first) begin
			next_pslverr = !addr_mapped(paddr) || (pwrite && !addr_writable(paddr));
		end
	end

	// pready rises with the answer, one edge after the first access cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
		end else if (clk_en) begin
			pready <= access_first;
		end
	end

	// error flag stands with pready for one cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pslverr <= next_pslverr;
		end
	end

	// read data stands with pready, zero otherwise
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= OFSW_UNMAPPED_READ;
		end else if (clk_en) begin
			prdata <= next_prdata;
		end
	end
endmodule
`default_nettype wire

// >>> verif/ofsw_checker.sv
// ofsw_checker: port-level assertions for the fault and status words
`timescale 1ns/10ps
`default_nettype none
module ofsw_checker
	import ofsw_pkg::*;
#(
	parameter int NUM_CH = 6
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NUM_CH-1:0] limit_alarm,
	input wire logic [NUM_CH-1:0] calibrating,
	input wire logic [NUM_CH-1:0] cal_error,
	input wire logic [NUM_CH-1:0] hold_active,
	input wire logic data_update,
	input wire logic comm_lost_pin,
	input wire logic [15:0] module_fault_summary_word,
	input wire logic [15:0] channel_fault_word,
	input wire logic [15:0] shared_channel_status_word
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// unused summary positions must stay quiet
	property p_summary_zero; (module_fault_summary_word & 16'h27FF) == 16'h0000; endproperty
	property p_analog_grp; module_fault_summary_word[15] == (|channel_fault_word); endproperty
	property p_output_grp; module_fault_summary_word[14] == (|channel_fault_word); endproperty
	// watchdog pin low for four edges so the synchroniser reads quiet
	property p_cal_force;
		clk_en && data_update && (|calibrating) && !(comm_lost_pin || $past(comm_lost_pin)
			|| $past(comm_lost_pin, 2) || $past(comm_lost_pin, 3))
			|=> channel_fault_word == OFSW_CF_CAL_PATTERN && module_fault_summary_word[12];
	endproperty
	property p_alarm;
		clk_en && data_update && !(|calibrating) && !(comm_lost_pin || $past(comm_lost_pin)
			|| $past(comm_lost_pin, 2) || $past(comm_lost_pin, 3))
			|=> channel_fault_word == 16'($past(limit_alarm));
	endproperty
	property p_cal_err;
		clk_en && data_update |=> module_fault_summary_word[11] == $past(|cal_error);
	endproperty
	property p_comm;
		clk_en && data_update && comm_lost_pin && $past(comm_lost_pin) && $past(comm_lost_pin, 2)
			&& $past(comm_lost_pin, 3) |=> channel_fault_word == 16'hFFFF;
	endproperty
	// odd status positions carry nothing
	property p_odd; (shared_channel_status_word & 16'hAAAA) == 16'h0000; endproperty
	property p_hold;
		clk_en && hold_active[0] ##1 clk_en && data_update |=> shared_channel_status_word[14];
	endproperty
	property p_ro; psel && penable && pwrite && pready && paddr < 8'h0C |-> pslverr; endproperty
	a_summary_zero: assert property (p_summary_zero) else $error("spare summary bit set");
	a_analog_grp: assert property (p_analog_grp) else $error("analog group flag wrong");
	a_output_grp: assert property (p_output_grp) else $error("output group flag wrong");
	a_cal_force: assert property (p_cal_force) else $error("calibration pattern missing");
	a_alarm: assert property (p_alarm) else $error("channel word not alarms");
	a_cal_err: assert property (p_cal_err) else $error("cal error flag wrong");
	a_comm: assert property (p_comm) else $error("comm loss pattern missing");
	a_odd: assert property (p_odd) else $error("odd status bit set");
	a_hold: assert property (p_hold) else $error("hold flag not set");
	a_ro: assert property (p_ro) else $error("word write accepted");
	c_cal: cover property (module_fault_summary_word[12]);
	c_comm: cover property (channel_fault_word == 16'hFFFF);
	c_hold: cover property (shared_channel_status_word[14]);
endmodule
`default_nettype wire

// >>> verif/ofsw_ctrl_model.sv
// ofsw_ctrl_model: owning controller reading the words over apb
`timescale 1ns/10ps
`default_nettype none
module ofsw_ctrl_model (
	input wire logic sys_clk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end
	// one transfer; request held until pready is seen, the bench watchdog bounds a hang
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> verif/tb_ofsw_top.sv
// tb_ofsw_top: directed tests of the fault and status words
`timescale 1ns/10ps
`default_nettype none
module tb_ofsw_top;
	import ofsw_pkg::*;
	logic sys_clk, rst_n, clk_en, data_update, comm_lost_pin, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] limit_alarm, calibrating, cal_error, hold_active;
	logic [95:0] request_value, echo_value;
	logic [15:0] module_fault_summary_word, channel_fault_word, shared_channel_status_word;
	int fail_count, checks;
	// ------------------------------------------------------------
	// instances and helpers
	// ------------------------------------------------------------
	ofsw_top ofsw_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.limit_alarm(limit_alarm), .calibrating(calibrating), .cal_error(cal_error), .hold_active(hold_active),
		.request_value(request_value), .echo_value(echo_value), .data_update(data_update),
		.comm_lost_pin(comm_lost_pin), .module_fault_summary_word(module_fault_summary_word),
		.channel_fault_word(channel_fault_word), .shared_channel_status_word(shared_channel_status_word), .irq(irq));
	ofsw_ctrl_model ofsw_ctrl_model_inst (.sys_clk(sys_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		ofsw_ctrl_model_inst.xfer(1'b0, a, 32'h00000000, rd, err);
		chk(name, rd, exp);
	endtask
	// longest path is the two-flop watchdog sync plus the word register
	task automatic settle;
		repeat (5) @(posedge sys_clk);
	endtask
	task automatic results;
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, comm_lost_pin, limit_alarm, calibrating, cal_error, hold_active} = '0;
		{clk_en, data_update} = 2'b11;
		request_value = '0;
		echo_value = '0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd_chk("module word", OFSW_ADDR_MODULE_FAULT, 32'h00000000);
		ofsw_ctrl_model_inst.xfer(1'b1, OFSW_ADDR_IRQ_MASK, 32'h00000001, rd, err);
		chk("mask write error", 32'(err), 32'h00000000);
		limit_alarm <= 6'h21;
		settle();
		chk("irq raised", 32'(irq), 32'h00000001);
		rd_chk("channel word", OFSW_ADDR_CHANNEL_FAULT, 32'h00000021);
		rd_chk("module word", OFSW_ADDR_MODULE_FAULT, 32'h0000C000);
		rd_chk("irq status", OFSW_ADDR_IRQ_STATUS, 32'h00000001);
		settle();
		chk("irq cleared", 32'(irq), 32'h00000000);
		calibrating <= 6'h08;
		cal_error <= 6'h02;
		settle();
		rd_chk("channel word", OFSW_ADDR_CHANNEL_FAULT, 32'h0000003F);
		rd_chk("module word", OFSW_ADDR_MODULE_FAULT, 32'h0000D800);
		calibrating <= 6'h00;
		comm_lost_pin <= 1'b1;
		settle();
		rd_chk("channel word", OFSW_ADDR_CHANNEL_FAULT, 32'h0000FFFF);
		rd_chk("module word", OFSW_ADDR_MODULE_FAULT, 32'h0000C800);
		{comm_lost_pin, cal_error, limit_alarm} <= '0;
		settle();
		rd_chk("module word", OFSW_ADDR_MODULE_FAULT, 32'h00000000);
		// no data update: words hold; free run then refreshes every cycle
		data_update <= 1'b0;
		limit_alarm <= 6'h04;
		settle();
		rd_chk("frozen channel word", OFSW_ADDR_CHANNEL_FAULT, 32'h00000000);
		ofsw_ctrl_model_inst.xfer(1'b1, OFSW_ADDR_CONTROL, 32'h00000001, rd, err);
		settle();
		rd_chk("free run channel word", OFSW_ADDR_CHANNEL_FAULT, 32'h00000004);
		rd_chk("control", OFSW_ADDR_CONTROL, 32'h00000001);
		ofsw_ctrl_model_inst.xfer(1'b1, OFSW_ADDR_CONTROL, 32'h00000000, rd, err);
		data_update <= 1'b1;
		limit_alarm <= 6'h00;
		settle();
		ofsw_ctrl_model_inst.xfer(1'b1, OFSW_ADDR_CHANNEL_STATUS, 32'h0000FFFF, rd, err);
		chk("word write refused", 32'(err), 32'h00000001);
		ofsw_ctrl_model_inst.xfer(1'b0, 8'h3C, 32'h00000000, rd, err);
		chk("unmapped refused", 32'(err), 32'h00000001);
		chk("unmapped data", rd, OFSW_UNMAPPED_READ);
		// equal request and echo lets each earlier channel release
		for (int i = 0; i < 6; i++) begin
			hold_active <= 6'(1 << i);
			settle();
			rd_chk("status word", OFSW_ADDR_CHANNEL_STATUS, 32'(1 << (14 - 2 * i)));
		end
		request_value[95:80] <= 16'h1000;
		echo_value[95:80] <= 16'h1042;
		hold_active <= 6'h00;
		settle();
		rd_chk("status word", OFSW_ADDR_CHANNEL_STATUS, 32'h00000010);
		echo_value[95:80] <= 16'h1041;
		settle();
		rd_chk("status word", OFSW_ADDR_CHANNEL_STATUS, 32'h00000000);
		results();
	end
	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		#100us;
		fail_count++;
		results();
	end
endmodule
bind ofsw_top ofsw_checker #(.NUM_CH(NUM_CH)) ofsw_checker_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.limit_alarm(limit_alarm), .calibrating(calibrating), .cal_error(cal_error), .hold_active(hold_active),
	.data_update(data_update), .comm_lost_pin(comm_lost_pin), .module_fault_summary_word(module_fault_summary_word),
	.channel_fault_word(channel_fault_word), .shared_channel_status_word(shared_channel_status_word));
`default_nettype wire
